// ===== hdl/adc_pkg.sv
// package: register map, field layout and timing constants for antenna diversity / cca
package adc_pkg;
  // register word indices (byte address is index * 4, since some offsets are not word multiples)
  localparam logic [7:0] ADC_IDX_INT_STATUS_TWO  = 8'h04;
  localparam logic [7:0] ADC_IDX_INT_ENABLE_TWO  = 8'h06;
  localparam logic [7:0] ADC_IDX_OP_FUNC_CTRL_TWO = 8'h08;
  localparam logic [7:0] ADC_IDX_PIN_CFG_ZERO    = 8'h0B;
  localparam logic [7:0] ADC_IDX_PIN_CFG_ONE     = 8'h0C;
  localparam logic [7:0] ADC_IDX_PIN_CFG_TWO     = 8'h0D;
  localparam logic [7:0] ADC_IDX_STRENGTH        = 8'h26;
  localparam logic [7:0] ADC_IDX_THRESHOLD       = 8'h27;
  localparam int         ADC_ADDR_W              = 10;
  // reset values
  localparam logic [7:0] ADC_RST_OP_FUNC_CTRL_TWO = 8'h00;
  localparam logic [7:0] ADC_RST_THRESHOLD        = 8'h00;
  localparam logic [7:0] ADC_RST_INT_ENABLE_TWO   = 8'h00;
  localparam logic [7:0] ADC_RST_PIN_CFG          = 8'h00;
  // field positions
  localparam int ADC_MODE_LSB      = 5;
  localparam int ADC_STRENGTH_BIT  = 4;
  localparam int ADC_PIN_FUNC_W    = 5;
  localparam logic [3:0] ADC_PIN_FUNC_CCA     = 4'hE;
  localparam logic [4:0] ADC_PIN_FUNC_ANT_ONE = 5'h17;
  localparam logic [4:0] ADC_PIN_FUNC_ANT_TWO = 5'h18;
  // timing
  localparam int ADC_CLK_MHZ       = 100;
  localparam int ADC_REFRESH_BITS  = 4;
  localparam int ADC_DWELL_NS      = 8000;
  localparam int ADC_DWELL_CYC     = (ADC_DWELL_NS * ADC_CLK_MHZ) / 1000;
  localparam int ADC_BEACON_NS     = 4000;
  localparam int ADC_BEACON_CYC    = (ADC_BEACON_NS * ADC_CLK_MHZ) / 1000;
  typedef enum logic [2:0] {
    ADC_ST_IDLE    = 3'b000,
    ADC_ST_MEAS_A  = 3'b001,
    ADC_ST_MEAS_B  = 3'b010,
    ADC_ST_HOLD    = 3'b011
  } adc_state_e;
endpackage

// ===== hdl/adc_strength_hold.sv
// file: strength sample register refreshed on a periodic enable
`timescale 1ns/1ns
module adc_strength_hold
  import adc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_data,
  output logic      [WIDTH-1:0] o_data
);
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_data <= '0;
    end else if (i_load) begin
      o_data <= i_data;
    end
  end
endmodule

// ===== hdl/adc_antenna_diversity_cca.sv
// file: antenna diversity switch control, signal strength and clear channel assessment
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// [RL1] entering receive in algorithm mode restarts comparison
// [RL2] evaluation happens during the preamble
// [RL3] stronger antenna held for rest of packet
// [RL4] chosen antenna reused for next transmit
// [RL5] mode is three top bits of 08h
// [RL6] fixed modes drive table levels
// [RL7] modes 100/101 toggle until packet arrives
// [RL8] modes 110/111 beacon variant, synchronous arrival
// [RL9] sender uses eight byte preamble
// [RL10] beacon sender uses four byte preamble
// [RL11] strength is unsigned, half dB steps
// [RL12] strength register 26h, read only
// [RL13] strength refreshed every four bit periods
// [RL14] host polls carefully or uses threshold
// [RL15] threshold register 27h resets to zero
// [RL16] above threshold sets flag in 04h
// [RL17] pin function 1110 outputs threshold status
// [RL18] dedicated pin copies antenna two output
// [RL19] enabled events pull interrupt low
// [RL20] status read clears flag and interrupt
module adc_antenna_diversity_cca
  import adc_pkg::*;
#(
  parameter int NUM_PINS   = 3,
  parameter int DWELL_CYC  = ADC_DWELL_CYC,
  parameter int BEACON_CYC = ADC_BEACON_CYC
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // avalon-mm slave
  input  wire logic [ADC_ADDR_W-1:0] i_avs_address,
  input  wire logic                  i_avs_read,
  input  wire logic                  i_avs_write,
  input  wire logic [31:0]           i_avs_writedata,
  input  wire logic [3:0]            i_avs_byteenable,
  output logic      [31:0]           o_avs_readdata,
  output logic                       o_avs_waitrequest,
  output logic      [1:0]            o_avs_response,
  // radio side
  input  wire logic                  i_rx_state,
  input  wire logic                  i_tx_state,
  input  wire logic                  i_preamble_detect,
  input  wire logic                  i_packet_end,
  input  wire logic [7:0]            i_strength_level,
  input  wire logic                  i_bit_tick,
  // switch and pins
  output logic                       o_antenna_one_switch_out,
  output logic                       o_antenna_two_switch_out,
  output logic                       o_antenna_pin,
  output logic      [NUM_PINS-1:0]   o_radio_pin_x,
  output logic                       o_radio_interrupt_out_n
);
  // ==========================================================
  // registers and state
  // ==========================================================
  logic [7:0]                  op_ctrl_reg;
  logic [7:0]                  threshold_reg;
  logic [7:0]                  int_enable_reg;
  logic [ADC_PIN_FUNC_W-1:0]   pin_func_reg [NUM_PINS];
  logic                        strength_flag_reg;
  logic                        cca_status_reg;
  logic                        ant_sel_reg;
  logic                        ant_try_reg;
  logic [7:0]                  best_level_reg;
  logic [15:0]                 dwell_cnt_reg;
  logic [1:0]                  bit_cnt_reg;
  logic                        rx_prev_reg;
  logic                        ack_reg;
  logic [31:0]                 rdata_reg;
  logic [1:0]                  resp_reg;
  adc_state_e                  state_reg;
  logic [7:0]                  strength_value;
  logic [2:0]                  mode;
  logic                        active;
  logic                        algo_mode;
  logic                        beacon_mode;
  logic                        refresh;
  logic                        rx_start;
  logic [7:0]                  pin_cfg_rd;
  logic                        pin_cfg_hit;
  logic                        status_read;
  logic                        wr_strobe;
  logic [7:0]                  idx;
  logic [15:0]                 dwell_limit;
  logic                        ant_out;

  assign mode        = op_ctrl_reg[ADC_MODE_LSB +: 3]; // RL5
  assign active      = i_rx_state | i_tx_state;
  assign algo_mode   = mode[2];
  assign beacon_mode = mode[2] & mode[1]; // RL8
  assign idx         = i_avs_address[ADC_ADDR_W-1:2];
  assign rx_start    = i_rx_state & ~rx_prev_reg;
  assign dwell_limit = beacon_mode ? 16'(BEACON_CYC) : 16'(DWELL_CYC);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  // level both switch outputs take outside receive and transmit
  function automatic logic idle_level(input logic [2:0] m);
    idle_level = m[2] ? m[0] : m[1];
  endfunction

  // ==========================================================
  // strength refresh every four bit periods
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt_reg <= 2'h0;
    end else if (i_bit_tick) begin
      bit_cnt_reg <= bit_cnt_reg + 2'h1;
    end
  end
  assign refresh = i_bit_tick && (bit_cnt_reg == 2'(ADC_REFRESH_BITS - 1)); // RL13

  adc_strength_hold #(
    .WIDTH (8)
  ) u_hold (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_load  (refresh),
    .i_data  (i_strength_level),
    .o_data  (strength_value)
  ); // RL11

  // ==========================================================
  // diversity algorithm
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_prev_reg <= 1'b0;
    end else begin
      rx_prev_reg <= i_rx_state;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg      <= ADC_ST_IDLE;
      ant_try_reg    <= 1'b0;
      ant_sel_reg    <= 1'b0;
      best_level_reg <= 8'h00;
      dwell_cnt_reg  <= 16'h0000;
    end else if (!algo_mode || !i_rx_state) begin
      state_reg     <= ADC_ST_IDLE;
      dwell_cnt_reg <= 16'h0000;
    end else if (rx_start) begin
      state_reg      <= ADC_ST_MEAS_A; // RL1
      ant_try_reg    <= 1'b0;
      best_level_reg <= 8'h00;
      dwell_cnt_reg  <= 16'h0000;
    end else begin
      case (state_reg)
        ADC_ST_MEAS_A, ADC_ST_MEAS_B: begin
          // live level is judged, the switch already sits on the tried antenna
          if (dwell_cnt_reg >= dwell_limit - 16'h0001) begin
            dwell_cnt_reg <= 16'h0000;
            if (i_strength_level > best_level_reg ||
                state_reg == ADC_ST_MEAS_A) begin
              best_level_reg <= i_strength_level;
              ant_sel_reg    <= ant_try_reg; // RL3
            end
            if (i_preamble_detect && state_reg == ADC_ST_MEAS_B) begin
              state_reg <= ADC_ST_HOLD; // RL2
            end else begin
              state_reg   <= (state_reg == ADC_ST_MEAS_A) ? ADC_ST_MEAS_B : ADC_ST_MEAS_A;
              ant_try_reg <= ~ant_try_reg; // RL7
            end
          end else begin
            dwell_cnt_reg <= dwell_cnt_reg + 16'h0001;
          end
        end
        ADC_ST_HOLD: begin
          if (i_packet_end) begin
            state_reg <= ADC_ST_IDLE;
          end
        end
        default: begin
          state_reg <= ADC_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // switch outputs
  // ==========================================================
  always_comb begin
    ant_out = 1'b0;
    if (!algo_mode) begin
      ant_out = mode[0]; // RL6
    end else if (i_rx_state && (state_reg == ADC_ST_MEAS_A || state_reg == ADC_ST_MEAS_B)) begin
      ant_out = ~ant_try_reg;
    end else begin
      ant_out = ~ant_sel_reg; // RL4
    end
  end

  always_comb begin
    if (active) begin
      o_antenna_one_switch_out = ant_out;
      o_antenna_two_switch_out = ~ant_out;
    end else begin
      o_antenna_one_switch_out = idle_level(mode); // RL7
      o_antenna_two_switch_out = idle_level(mode); // RL7
    end
  end
  assign o_antenna_pin = o_antenna_two_switch_out; // RL18

  // ==========================================================
  // clear channel assessment
  // status holds the last preamble decision until receive ends
  // ==========================================================
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cca_status_reg <= 1'b0;
    end else if (i_preamble_detect) begin
      cca_status_reg <= (strength_value > threshold_reg); // RL16
    end else if (!i_rx_state) begin
      cca_status_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strength_flag_reg <= 1'b0;
    end else if (i_preamble_detect && (strength_value > threshold_reg)) begin
      strength_flag_reg <= 1'b1; // RL16
    end else if (status_read) begin
      strength_flag_reg <= 1'b0; // RL20
    end
  end

  // interrupt follows the flag only while its enable bit is set
  assign o_radio_interrupt_out_n =
    ~(strength_flag_reg & int_enable_reg[ADC_STRENGTH_BIT]); // RL19

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
      always_comb begin
        if (pin_func_reg[gp][3:0] == ADC_PIN_FUNC_CCA && !pin_func_reg[gp][4]) begin
          o_radio_pin_x[gp] = cca_status_reg; // RL17
        end else if (pin_func_reg[gp] == ADC_PIN_FUNC_ANT_ONE) begin
          o_radio_pin_x[gp] = o_antenna_one_switch_out;
        end else if (pin_func_reg[gp] == ADC_PIN_FUNC_ANT_TWO) begin
          o_radio_pin_x[gp] = o_antenna_two_switch_out;
        end else begin
          o_radio_pin_x[gp] = 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // avalon-mm slave, one wait cycle per access
  // ==========================================================
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_reg;
  assign wr_strobe   = i_avs_write & ack_reg & i_avs_byteenable[0];
  assign status_read = i_avs_read & ack_reg & hit(idx, ADC_IDX_INT_STATUS_TWO); // RL20
  assign o_avs_readdata = rdata_reg;
  assign o_avs_response = resp_reg;

  // pin configuration readback, one word per pin
  always_comb begin
    pin_cfg_rd  = 8'h00;
    pin_cfg_hit = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (hit(idx, ADC_IDX_PIN_CFG_ZERO + 8'(p))) begin
        pin_cfg_rd[ADC_PIN_FUNC_W-1:0] = pin_func_reg[p];
        pin_cfg_hit                    = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (i_avs_read | i_avs_write) & ~ack_reg;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_reg <= 32'h0000_0000;
      resp_reg  <= 2'h0;
    end else if ((i_avs_read | i_avs_write) && !ack_reg) begin
      rdata_reg <= 32'h0000_0000;
      resp_reg  <= 2'h0;
      if (hit(idx, ADC_IDX_OP_FUNC_CTRL_TWO)) begin
        rdata_reg[7:0] <= op_ctrl_reg;
      end else if (hit(idx, ADC_IDX_STRENGTH)) begin
        rdata_reg[7:0] <= strength_value; // RL12
      end else if (hit(idx, ADC_IDX_THRESHOLD)) begin
        rdata_reg[7:0] <= threshold_reg;
      end else if (hit(idx, ADC_IDX_INT_STATUS_TWO)) begin
        rdata_reg[ADC_STRENGTH_BIT] <= strength_flag_reg;
      end else if (hit(idx, ADC_IDX_INT_ENABLE_TWO)) begin
        rdata_reg[7:0] <= int_enable_reg;
      end else if (pin_cfg_hit) begin
        rdata_reg[7:0] <= pin_cfg_rd;
      end else begin
        resp_reg <= 2'h2;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      op_ctrl_reg <= ADC_RST_OP_FUNC_CTRL_TWO; // RL5
    end else if (wr_strobe && hit(idx, ADC_IDX_OP_FUNC_CTRL_TWO)) begin
      op_ctrl_reg <= i_avs_writedata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      threshold_reg <= ADC_RST_THRESHOLD; // RL15
    end else if (wr_strobe && hit(idx, ADC_IDX_THRESHOLD)) begin
      threshold_reg <= i_avs_writedata[7:0]; // RL15
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      int_enable_reg <= ADC_RST_INT_ENABLE_TWO;
    end else if (wr_strobe && hit(idx, ADC_IDX_INT_ENABLE_TWO)) begin
      int_enable_reg <= i_avs_writedata[7:0];
    end
  end

  generate
    for (gp = 0; gp < NUM_PINS; gp++) begin : g_cfg
      always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          pin_func_reg[gp] <= ADC_RST_PIN_CFG[ADC_PIN_FUNC_W-1:0];
        end else if (wr_strobe && hit(idx, ADC_IDX_PIN_CFG_ZERO + 8'(gp))) begin
          pin_func_reg[gp] <= i_avs_writedata[ADC_PIN_FUNC_W-1:0];
        end
      end
    end
  endgenerate
endmodule

// ===== test/adc_antenna_diversity_cca_checker.sv
// checker: port-level assertions for antenna diversity and cca
`timescale 1ns/1ns
module adc_antenna_diversity_cca_checker
  import adc_pkg::*;
(
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  input wire logic [ADC_ADDR_W-1:0] i_avs_address,
  input wire logic                  i_avs_read,
  input wire logic                  i_avs_write,
  input wire logic [31:0]           i_avs_writedata,
  input wire logic [3:0]            i_avs_byteenable,
  input wire logic [31:0]           o_avs_readdata,
  input wire logic                  o_avs_waitrequest,
  input wire logic [1:0]            o_avs_response,
  input wire logic                  i_rx_state,
  input wire logic                  i_tx_state,
  input wire logic                  i_preamble_detect,
  input wire logic                  o_antenna_one_switch_out,
  input wire logic                  o_antenna_two_switch_out,
  input wire logic                  o_antenna_pin,
  input wire logic                  o_radio_interrupt_out_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  logic [2:0] mode_reg;
  wire logic [7:0] idx     = i_avs_address[9:2];
  wire logic       active  = i_rx_state | i_tx_state;
  wire logic       take_wr = i_avs_write & ~o_avs_waitrequest & i_avs_byteenable[0];
  wire logic       take_rd = i_avs_read & ~o_avs_waitrequest;
  wire logic       idle_lv = mode_reg[2] ? mode_reg[0] : mode_reg[1];
  wire logic       mapped  = idx inside {8'h04, 8'h06, 8'h08, 8'h0B, 8'h0C, 8'h0D, 8'h26, 8'h27};
  // ====================
  // shadow of the mode field
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) mode_reg <= 3'h0;
    else if (take_wr && idx == ADC_IDX_OP_FUNC_CTRL_TWO) mode_reg <= i_avs_writedata[7:5];
  end
  // ====================
  // properties
  sequence s_wait_then_go;
    o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  property p_pin_copy;
    o_antenna_pin == o_antenna_two_switch_out;
  endproperty
  property p_fixed;
    !mode_reg[2] && active |-> o_antenna_one_switch_out == mode_reg[0] &&
                               o_antenna_two_switch_out == !mode_reg[0];
  endproperty
  property p_idle;
    !active |-> o_antenna_one_switch_out == idle_lv && o_antenna_two_switch_out == idle_lv;
  endproperty
  property p_alg;
    mode_reg[2] && active |-> o_antenna_one_switch_out != o_antenna_two_switch_out;
  endproperty
  property p_clear;
    take_rd && idx == ADC_IDX_INT_STATUS_TWO && !i_preamble_detect |=> o_radio_interrupt_out_n;
  endproperty
  property p_handshake;
    $rose(i_avs_read | i_avs_write) |-> s_wait_then_go;
  endproperty
  property p_unmapped;
    take_rd && !mapped |-> o_avs_response == 2'b10 && o_avs_readdata == 32'h0;
  endproperty
  property p_irq;
    $fell(o_radio_interrupt_out_n) |-> $past(i_preamble_detect) || $past(take_wr);
  endproperty
  a_pin_copy: assert property (p_pin_copy)
    else $error("antenna pin differs from switch two");
  a_fixed: assert property (p_fixed)
    else $error("fixed mode switch levels wrong");
  a_idle: assert property (p_idle)
    else $error("idle switch levels wrong");
  a_alg: assert property (p_alg)
    else $error("algorithm mode drives both or neither antenna");
  a_clear: assert property (p_clear)
    else $error("interrupt not released after status read");
  a_handshake: assert property (p_handshake)
    else $error("waitrequest sequence wrong");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not refused");
  a_irq: assert property (p_irq)
    else $error("interrupt asserted without cause");
endmodule
bind adc_antenna_diversity_cca adc_antenna_diversity_cca_checker u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_avs_response(o_avs_response),
  .i_rx_state(i_rx_state), .i_tx_state(i_tx_state), .i_preamble_detect(i_preamble_detect),
  .o_antenna_one_switch_out(o_antenna_one_switch_out),
  .o_antenna_two_switch_out(o_antenna_two_switch_out),
  .o_antenna_pin(o_antenna_pin), .o_radio_interrupt_out_n(o_radio_interrupt_out_n));

// ===== test/adc_rf_switch_model.sv
// model: rf switch with two antennas feeding the strength detector
`timescale 1ns/1ns
module adc_rf_switch_model (
  input  wire logic       i_sel_one,
  input  wire logic       i_sel_two,
  input  wire logic [7:0] i_level_one,
  input  wire logic [7:0] i_level_two,
  output logic      [7:0] o_strength_level
);
  // both or neither path closed: no antenna, floor level
  always_comb begin
    if (i_sel_one && !i_sel_two) o_strength_level = i_level_one;
    else if (i_sel_two && !i_sel_one) o_strength_level = i_level_two;
    else o_strength_level = 8'h00;
  end
endmodule

// ===== test/adc_antenna_diversity_cca_test.sv
// testbench: antenna diversity and cca block
`timescale 1ns/1ns
module adc_antenna_diversity_cca_test
  import adc_pkg::*;
;
  logic i_clk = 0, i_rst_n = 0, rd = 0, wr = 0, rx = 0, tx = 0, pre = 0, pend = 0, tick = 0;
  logic [9:0]  addr = '0;
  logic [31:0] wdata = '0, rv;
  logic [7:0]  lv1 = 8'h00, lv2 = 8'h00;
  logic [2:0]  tcnt = 3'h0;
  logic [1:0]  rsp;
  wire  [31:0] rdata;
  wire  [7:0]  level;
  wire  [2:0]  pins;
  wire  [1:0]  resp;
  wire         wait_req, a1, a2, apin, irq_n;
  wire  [31:0] ant = {30'h0, a1, a2};
  int bad_count = 0, samples_checked = 0;
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    tcnt <= tcnt + 3'h1;
    tick <= (tcnt == 3'h7);
  end
  adc_antenna_diversity_cca #(.NUM_PINS(3), .DWELL_CYC(4), .BEACON_CYC(2)) u_adc_antenna_diversity_cca (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdata), .i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .o_avs_response(resp), .i_rx_state(rx), .i_tx_state(tx),
    .i_preamble_detect(pre), .i_packet_end(pend), .i_strength_level(level), .i_bit_tick(tick),
    .o_antenna_one_switch_out(a1), .o_antenna_two_switch_out(a2), .o_antenna_pin(apin),
    .o_radio_pin_x(pins), .o_radio_interrupt_out_n(irq_n));
  adc_rf_switch_model u_adc_rf_switch_model (.i_sel_one(a1), .i_sel_two(a2),
    .i_level_one(lv1), .i_level_two(lv2), .o_strength_level(level));
  // ====================
  // shared tasks
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    addr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge i_clk);
      n++;
    end while (wait_req !== 1'b0 && n < 20);
    if (n >= 20) begin
      bad_count++;
      end_sim();
    end
    rv = rdata;
    rsp = resp;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic pulse_pre;
    @(posedge i_clk) pre <= 1'b1;
    @(posedge i_clk) pre <= 1'b0;
    repeat (2) @(negedge i_clk);
  endtask
  function automatic logic [31:0] pick(input logic one);
    return {30'h0, one, !one};
  endfunction
  // ====================
  // scenarios
  task automatic t_regs;
    bus(0, ADC_IDX_OP_FUNC_CTRL_TWO, 8'h00);
    chk(rv, {24'h0, ADC_RST_OP_FUNC_CTRL_TWO});
    bus(0, ADC_IDX_THRESHOLD, 8'h00);
    chk(rv, 32'h0);
    bus(1, ADC_IDX_THRESHOLD, 8'hA5);
    bus(0, ADC_IDX_THRESHOLD, 8'h00);
    chk(rv, 32'hA5);
    bus(1, ADC_IDX_STRENGTH, 8'h5A);
    bus(0, ADC_IDX_STRENGTH, 8'h00);
    chk(rv, 32'h0);
    bus(0, 8'h30, 8'h00);
    chk({rsp, rv[29:0]}, 32'h80000000);
  endtask
  task automatic t_fixed;
    for (int m = 0; m < 8; m++) begin
      bus(1, ADC_IDX_OP_FUNC_CTRL_TWO, {3'(m), 5'h00});
      @(negedge i_clk);
      chk(ant, {30'h0, {2{m[2] ? m[0] : m[1]}}});
      if (m < 4) begin
        @(posedge i_clk) rx <= 1'b1;
        @(negedge i_clk);
        chk(ant, pick(m[0]));
        chk(32'(apin), 32'(a2));
        @(posedge i_clk) rx <= 1'b0;
      end
    end
  endtask
  task automatic t_div(input logic [2:0] m, input logic [7:0] s1, s2, input logic one);
    logic first;
    int n;
    lv1 <= s1;
    lv2 <= s2;
    bus(1, ADC_IDX_OP_FUNC_CTRL_TWO, {m, 5'h00});
    @(posedge i_clk) rx <= 1'b1;
    @(negedge i_clk);
    first = a1;
    n = 0;
    while (a1 === first && n < 20) begin
      @(negedge i_clk);
      n++;
    end
    chk(32'(a1 !== first), 32'h1);
    // preamble held for several dwells, as a sender would
    @(posedge i_clk) pre <= 1'b1;
    repeat (40) @(posedge i_clk);
    pre <= 1'b0;
    repeat (10) begin
      @(negedge i_clk);
      chk(ant, pick(one));
    end
    @(posedge i_clk) pend <= 1'b1;
    @(posedge i_clk) pend <= 1'b0;
    rx <= 1'b0;
    @(posedge i_clk) tx <= 1'b1;
    @(negedge i_clk);
    chk(ant, pick(one));
    @(posedge i_clk) tx <= 1'b0;
  endtask
  task automatic t_cca;
    bus(1, ADC_IDX_THRESHOLD, 8'h40);
    bus(1, ADC_IDX_INT_ENABLE_TWO, 8'h10);
    bus(1, ADC_IDX_PIN_CFG_ZERO, 8'h0E);
    bus(1, ADC_IDX_PIN_CFG_ONE, {3'h0, ADC_PIN_FUNC_ANT_ONE});
    bus(1, ADC_IDX_PIN_CFG_TWO, {3'h0, ADC_PIN_FUNC_ANT_TWO});
    bus(1, ADC_IDX_OP_FUNC_CTRL_TWO, 8'h20);
    bus(0, ADC_IDX_INT_STATUS_TWO, 8'h00);
    lv1 <= 8'h40;
    @(posedge i_clk) rx <= 1'b1;
    repeat (40) @(posedge i_clk);
    bus(0, ADC_IDX_STRENGTH, 8'h00);
    chk(rv, 32'h40);
    bus(0, ADC_IDX_STRENGTH, 8'h00);
    chk(rv, 32'h40);
    chk(32'(pins[2:1]), 32'h1);
    pulse_pre();
    chk(32'(irq_n), 32'h1);
    @(posedge i_clk) lv1 <= 8'h41;
    repeat (40) @(posedge i_clk);
    pulse_pre();
    chk(32'(irq_n), 32'h0);
    chk(32'(pins[0]), 32'h1);
    bus(0, ADC_IDX_INT_STATUS_TWO, 8'h00);
    chk(32'(rv[4]), 32'h1);
    @(negedge i_clk);
    chk(32'(irq_n), 32'h1);
    bus(0, ADC_IDX_INT_STATUS_TWO, 8'h00);
    chk(32'(rv[4]), 32'h0);
    bus(1, ADC_IDX_INT_ENABLE_TWO, 8'h00);
    pulse_pre();
    chk(32'(irq_n), 32'h1);
    bus(0, ADC_IDX_INT_STATUS_TWO, 8'h00);
    chk(32'(rv[4]), 32'h1);
    @(posedge i_clk) rx <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_fixed();
    t_div(3'b100, 8'h20, 8'h60, 1'b0);
    t_div(3'b101, 8'h70, 8'h10, 1'b1);
    t_div(3'b110, 8'h60, 8'h20, 1'b1);
    t_div(3'b111, 8'h20, 8'h60, 1'b0);
    t_cca();
    end_sim();
  end
endmodule
